// ---- hdl/tcp_pair_buf.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// shared constants of the text command parser
// ----------------------------------------------------------------
package tcp_pkg;
  // characters, compared after case folding
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_Q = 8'h3F;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;
  // header store and parameter limits
  localparam int HDR_W = 80;
  localparam logic [3:0] HDR_CHARS = 4'hA;
  localparam logic [3:0] PARAM_MAX = 4'hA;
  localparam logic [HDR_W-1:0] HDR_VOLT = ":VOLT";
  localparam logic [HDR_W-1:0] HDR_VOLT_A = ":VOLT:A";
  localparam logic [HDR_W-1:0] HDR_VOLT_B = ":VOLT:B";
  localparam logic [HDR_W-1:0] HDR_CURR = ":CURR";
  localparam logic [HDR_W-1:0] HDR_CURR_A = ":CURR:A";
  localparam logic [HDR_W-1:0] HDR_CURR_B = ":CURR:B";
  localparam logic [HDR_W-1:0] HDR_ADDR = ":ADDR";
  // system addresses
  localparam logic [4:0] ADDR_MASTER = 5'h01;
  localparam logic [4:0] ADDR_MAX = 5'h1E;
  // values are held in hundredths
  localparam logic [13:0] INT_LIMIT = 14'h03E8;
  localparam logic [16:0] CENTI_PER_UNIT = 17'h00064;
  localparam logic [16:0] CENTI_PER_TENTH = 17'h0000A;
  localparam logic [16:0] CENTI_MAX = 17'h1869F;
  localparam logic [3:0] ROUND_DIGIT = 4'h5;
  // reply symbol positions: d d d . d d LF
  localparam logic [2:0] RP_UNITS = 3'h2;
  localparam logic [2:0] RP_DOT = 3'h3;
  localparam logic [2:0] RP_LAST = 3'h6;
  // synchronised pin bits
  localparam int SY_CTS = 0;
  localparam int SY_DUAL = 1;
  localparam int SY_SEQ = 2;
  localparam int SY_TRACK = 3;
  localparam int SY_EXT = 4;
  localparam int SY_W = 5;

  typedef enum logic [1:0] {ITEM_NONE, ITEM_VOLT, ITEM_CURR, ITEM_ADDR} tcp_item_t;
  typedef enum logic [1:0] {CHAN_NONE, CHAN_A, CHAN_B} tcp_chan_t;
endpackage

// ----------------------------------------------------------------
// two-entry buffer: output stage plus one skid entry
// ----------------------------------------------------------------
module tcp_pair_buf (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [7:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  logic [7:0] out_data_reg;
  logic out_valid_reg;
  logic [7:0] skid_data_reg;
  logic skid_valid_reg;
  logic load_out;
  logic in_fire;

  // ready depends only on a flop, so no path from out to in
  assign in_ready_o = !skid_valid_reg;
  assign in_fire = in_valid_i && !skid_valid_reg;
  assign load_out = !out_valid_reg || out_ready_i;
  assign out_data_o = out_data_reg;
  assign out_valid_o = out_valid_reg;

  // refill output from skid first to keep byte order
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= 8'h00;
      skid_valid_reg <= 1'b0;
      skid_data_reg <= 8'h00;
    end else if (load_out) begin
      if (skid_valid_reg) begin
        out_data_reg <= skid_data_reg;
        out_valid_reg <= 1'b1;
        skid_valid_reg <= 1'b0;
      end else begin
        out_data_reg <= in_data_i;
        out_valid_reg <= in_fire;
      end
    end else if (in_fire) begin
      skid_data_reg <= in_data_i;
      skid_valid_reg <= 1'b1;
    end
  end

  skid_order_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    skid_valid_reg && !load_out |=> skid_valid_reg && $stable(skid_data_reg))
    else $error("skid entry lost while output stalled");
endmodule // tcp_pair_buf

`default_nettype wire

// ---- hdl/tcp_text_cmd_parser.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - a line acts only once its line_terminator byte has arrived
// - parameter characters past the tenth are ignored
// - integer_parameter_form and decimal_parameter_form give one value form
// - fraction finer than hundredths is rounded half up
// - replies hold only the value and a terminator
// - header letters match regardless of case
// - address command picks target; other lines forwarded while slave selected
// - target is address one (master) after reset
// - suffix A picks output_channel_one, B output_channel_two
// - channel suffix on single-channel unit is rejected with error
// - settings conflicting with sequence, tracking or external control fail
// - transmission stops while partner drops its handshake
// - handshake held off while a command executes or replies
// - system address accepted only from one to thirty
module tcp_text_cmd_parser import tcp_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output logic rts_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic cts_i,
  input wire logic dual_chan_i,
  input wire logic seq_active_i,
  input wire logic track_active_i,
  input wire logic ext_active_i,
  output logic set_valid_o,
  output tcp_item_t set_item_o,
  output logic set_chan_o,
  output logic [16:0] set_value_o,
  output logic [4:0] addr_o,
  output logic err_o,
  output logic [7:0] fwd_data_o,
  output logic fwd_valid_o
);
  typedef enum logic [2:0] {S_HDR, S_PARAM, S_QTAIL, S_EXEC, S_REPLY} tcp_state_t;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  tcp_state_t state_reg, state_next;
  logic [SY_W-1:0] sync_a_reg, sync_b_reg;
  logic rx_ready_reg, rx_take;
  logic [7:0] ch;
  logic [HDR_W-1:0] hdr_reg;
  logic [3:0] hdr_len_reg, pcount_reg;
  logic hdr_long_reg, query_reg;
  logic [13:0] int_reg;
  logic [3:0] frac_reg [3];
  logic [1:0] nfrac_reg;
  logic has_dot_reg, has_digit_reg, bad_reg, over_reg;
  logic [16:0] vset_reg [2];
  logic [16:0] cset_reg [2];
  logic [4:0] addr_reg;
  tcp_item_t item;
  tcp_chan_t chan;
  logic is_master, num_ok, ch_idx, is_digit;
  logic [16:0] centi;
  logic exec_err, exec_set, do_reply, addr_load;
  logic set_valid_reg, set_chan_reg, err_reg;
  tcp_item_t set_item_reg;
  logic [16:0] set_value_reg;
  logic [2:0] rp_idx_reg;
  logic [16:0] rp_rem_reg, rp_w;
  logic [3:0] rp_dig_reg;
  logic rp_lead_reg, rp_digpos, rp_step, rp_skip;
  logic push_valid, push_fire, buf_in_ready, buf_valid, buf_pull;
  logic [7:0] push_data, buf_data, tx_data_reg, fwd_data_reg;
  logic tx_valid_reg, fwd_valid_reg;
  logic cts_s, dual_s, seq_s, track_s, ext_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= CH_LA && c <= CH_LZ) ? (c & ~CASE_BIT) : c;
  endfunction

  function automatic tcp_item_t hdr_item(input logic [HDR_W-1:0] h);
    if (h == HDR_VOLT || h == HDR_VOLT_A || h == HDR_VOLT_B)
      hdr_item = ITEM_VOLT;
    else if (h == HDR_CURR || h == HDR_CURR_A || h == HDR_CURR_B)
      hdr_item = ITEM_CURR;
    else if (h == HDR_ADDR)
      hdr_item = ITEM_ADDR;
    else
      hdr_item = ITEM_NONE;
  endfunction

  function automatic tcp_chan_t hdr_chan(input logic [HDR_W-1:0] h);
    if (h == HDR_VOLT_A || h == HDR_CURR_A)
      hdr_chan = CHAN_A;
    else if (h == HDR_VOLT_B || h == HDR_CURR_B)
      hdr_chan = CHAN_B;
    else
      hdr_chan = CHAN_NONE;
  endfunction

  // weight of each reply digit position in hundredths
  function automatic logic [16:0] rp_weight(input logic [2:0] idx);
    case (idx)
      3'h0: rp_weight = CENTI_PER_UNIT * CENTI_PER_UNIT;
      3'h1: rp_weight = CENTI_PER_UNIT * CENTI_PER_TENTH;
      3'h2: rp_weight = CENTI_PER_UNIT;
      3'h4: rp_weight = CENTI_PER_TENTH;
      default: rp_weight = 17'h00001;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and receive handshake
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
    end else begin
      sync_a_reg <= {ext_active_i, track_active_i, seq_active_i,
                     dual_chan_i, cts_i};
      sync_b_reg <= sync_a_reg;
    end
  end
  assign cts_s = sync_b_reg[SY_CTS];
  assign dual_s = sync_b_reg[SY_DUAL];
  assign seq_s = sync_b_reg[SY_SEQ];
  assign track_s = sync_b_reg[SY_TRACK];
  assign ext_s = sync_b_reg[SY_EXT];

  // host held off from the terminator until the reply is queued
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i)
      rx_ready_reg <= 1'b0;
    else
      rx_ready_reg <= (state_next == S_HDR || state_next == S_PARAM ||
                       state_next == S_QTAIL);
  end
  assign rx_take = rx_valid_i && rx_ready_reg;
  assign ch = upcase(rx_data_i);
  assign is_digit = ch >= CH_0 && ch <= CH_9;

  // ----------------------------------------------------------------
  // line state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_HDR: begin
        if (rx_take && ch == CH_LF)
          state_next = S_EXEC;
        else if (rx_take && ch == CH_SP)
          state_next = S_PARAM;
        else if (rx_take && ch == CH_Q)
          state_next = S_QTAIL;
      end
      S_PARAM, S_QTAIL: begin
        if (rx_take && ch == CH_LF)
          state_next = S_EXEC;
      end
      S_EXEC: state_next = do_reply ? S_REPLY : S_HDR;
      S_REPLY: begin
        if (push_fire && rp_idx_reg == RP_LAST)
          state_next = S_HDR;
      end
      default: state_next = S_HDR;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i)
      state_reg <= S_HDR;
    else
      state_reg <= state_next;
  end

  // header collection; overlong headers never match
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hdr_reg <= '0;
      hdr_len_reg <= 4'h0;
      hdr_long_reg <= 1'b0;
      query_reg <= 1'b0;
    end else if (state_reg == S_EXEC) begin
      hdr_reg <= '0;
      hdr_len_reg <= 4'h0;
      hdr_long_reg <= 1'b0;
      query_reg <= 1'b0;
    end else if (state_reg == S_HDR && rx_take && ch != CH_LF &&
                 ch != CH_SP) begin
      if (ch == CH_Q)
        query_reg <= 1'b1;
      else if (hdr_len_reg < HDR_CHARS) begin
        hdr_reg <= {hdr_reg[HDR_W-9:0], ch};
        hdr_len_reg <= hdr_len_reg + 4'h1;
      end else
        hdr_long_reg <= 1'b1;
    end
  end

  // parameter digits, both number forms into one value
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pcount_reg <= 4'h0;
      int_reg <= 14'h0000;
      frac_reg <= '{default: 4'h0};
      nfrac_reg <= 2'h0;
      has_dot_reg <= 1'b0;
      has_digit_reg <= 1'b0;
      bad_reg <= 1'b0;
      over_reg <= 1'b0;
    end else if (state_reg == S_EXEC) begin
      pcount_reg <= 4'h0;
      int_reg <= 14'h0000;
      frac_reg <= '{default: 4'h0};
      nfrac_reg <= 2'h0;
      has_dot_reg <= 1'b0;
      has_digit_reg <= 1'b0;
      bad_reg <= 1'b0;
      over_reg <= 1'b0;
    end else if (state_reg == S_QTAIL && rx_take && ch != CH_LF) begin
      bad_reg <= 1'b1;
    end else if (state_reg == S_PARAM && rx_take && ch != CH_LF &&
                 ch != CH_SP && pcount_reg < PARAM_MAX) begin
      pcount_reg <= pcount_reg + 4'h1;
      if (is_digit) begin
        has_digit_reg <= 1'b1;
        if (!has_dot_reg) begin
          if (!over_reg)
            int_reg <= 14'(int_reg * 14'h000A) + 14'(ch - CH_0);
          if (14'(int_reg * 14'h000A) + 14'(ch - CH_0) >= INT_LIMIT)
            over_reg <= 1'b1;
        end else if (nfrac_reg < 2'h3) begin
          frac_reg[nfrac_reg] <= 4'(ch - CH_0);
          nfrac_reg <= nfrac_reg + 2'h1;
        end
      end else if (ch == CH_DOT && !has_dot_reg)
        has_dot_reg <= 1'b1;
      else
        bad_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // execution decision
  // ----------------------------------------------------------------
  // third fraction digit rounds the hundredths half up
  assign centi = 17'({3'h0, int_reg} * CENTI_PER_UNIT) +
                 17'({13'h0000, frac_reg[0]} * CENTI_PER_TENTH) +
                 {13'h0000, frac_reg[1]} +
                 {16'h0000, frac_reg[2] >= ROUND_DIGIT};
  assign item = hdr_item(hdr_reg);
  assign chan = hdr_chan(hdr_reg);
  assign is_master = addr_reg == ADDR_MASTER;
  assign num_ok = has_digit_reg && !bad_reg && !over_reg;
  assign ch_idx = chan == CHAN_B;
  assign addr_load = state_reg == S_EXEC && item == ITEM_ADDR && exec_set;

  always_comb begin
    exec_err = 1'b0;
    exec_set = 1'b0;
    do_reply = 1'b0;
    if (!is_master && item != ITEM_ADDR) begin
      exec_err = 1'b0; // line went to the selected slave
    end else if (hdr_long_reg || item == ITEM_NONE) begin
      exec_err = 1'b1;
    end else if (item == ITEM_ADDR) begin
      if (query_reg || !num_ok || has_dot_reg || int_reg == 14'h0000 ||
          int_reg > {9'h000, ADDR_MAX})
        exec_err = 1'b1;
      else
        exec_set = 1'b1;
    end else if (dual_s != (chan != CHAN_NONE)) begin
      exec_err = 1'b1;
    end else if (query_reg) begin
      exec_err = bad_reg;
      do_reply = !bad_reg;
    end else if (!num_ok || centi > CENTI_MAX) begin
      exec_err = 1'b1;
    end else if (seq_s || ext_s || (track_s && ch_idx)) begin
      exec_err = 1'b1;
    end else begin
      exec_set = 1'b1;
    end
  end

  // stored settings; tracking copies channel one onto channel two
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      vset_reg <= '{default: 17'h00000};
      cset_reg <= '{default: 17'h00000};
      addr_reg <= ADDR_MASTER;
    end else if (state_reg == S_EXEC && exec_set) begin
      if (item == ITEM_ADDR)
        addr_reg <= int_reg[4:0];
      if (item == ITEM_VOLT) begin
        vset_reg[ch_idx] <= centi;
        if (track_s)
          vset_reg[1] <= centi;
      end
      if (item == ITEM_CURR) begin
        cset_reg[ch_idx] <= centi;
        if (track_s)
          cset_reg[1] <= centi;
      end
    end
  end

  // one-cycle result pulses toward the supply logic
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      set_valid_reg <= 1'b0;
      set_item_reg <= ITEM_NONE;
      set_chan_reg <= 1'b0;
      set_value_reg <= 17'h00000;
      err_reg <= 1'b0;
    end else begin
      set_valid_reg <= state_reg == S_EXEC && exec_set;
      err_reg <= state_reg == S_EXEC && exec_err;
      if (state_reg == S_EXEC && exec_set) begin
        set_item_reg <= item;
        set_chan_reg <= ch_idx;
        set_value_reg <= centi;
      end
    end
  end

  // bytes seen while a slave is selected go out on the local bus
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fwd_valid_reg <= 1'b0;
      fwd_data_reg <= 8'h00;
    end else begin
      fwd_valid_reg <= rx_take && !is_master;
      if (rx_take)
        fwd_data_reg <= rx_data_i;
    end
  end

  // ----------------------------------------------------------------
  // reply formatter: value only, no header
  // ----------------------------------------------------------------
  assign rp_w = rp_weight(rp_idx_reg);
  assign rp_digpos = rp_idx_reg != RP_DOT && rp_idx_reg != RP_LAST;
  assign rp_step = state_reg == S_REPLY && rp_digpos && rp_rem_reg >= rp_w;
  assign rp_skip = state_reg == S_REPLY && rp_digpos && !rp_step &&
                   rp_lead_reg && rp_dig_reg == 4'h0 &&
                   rp_idx_reg < RP_UNITS;

  always_comb begin
    push_valid = state_reg == S_REPLY && !rp_step && !rp_skip;
    if (rp_idx_reg == RP_DOT)
      push_data = CH_DOT;
    else if (rp_idx_reg == RP_LAST)
      push_data = CH_LF;
    else
      push_data = CH_0 + {4'h0, rp_dig_reg};
  end
  assign push_fire = push_valid && buf_in_ready;

  // digit by repeated subtraction; slow but tiny
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rp_idx_reg <= 3'h0;
      rp_rem_reg <= 17'h00000;
      rp_dig_reg <= 4'h0;
      rp_lead_reg <= 1'b1;
    end else if (state_reg == S_EXEC) begin
      rp_idx_reg <= 3'h0;
      rp_rem_reg <= (item == ITEM_VOLT) ? vset_reg[ch_idx]
                                        : cset_reg[ch_idx];
      rp_dig_reg <= 4'h0;
      rp_lead_reg <= 1'b1;
    end else if (rp_step) begin
      rp_rem_reg <= rp_rem_reg - rp_w;
      rp_dig_reg <= rp_dig_reg + 4'h1;
    end else if (rp_skip || push_fire) begin
      rp_idx_reg <= rp_idx_reg + 3'h1;
      rp_dig_reg <= 4'h0;
      if (push_fire && rp_digpos)
        rp_lead_reg <= 1'b0;
    end
  end

  tcp_pair_buf u_buf (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_data_i(push_data),
    .in_valid_i(push_valid),
    .in_ready_o(buf_in_ready),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pull)
  );

  // a byte already offered finishes; no new one while cts is low
  assign buf_pull = cts_s && (!tx_valid_reg || tx_ready_i);
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else if (buf_valid && buf_pull) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg <= buf_data;
    end else if (tx_ready_i)
      tx_valid_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rx_ready_o = rx_ready_reg;
  assign rts_o = rx_ready_reg;
  assign tx_data_o = tx_data_reg;
  assign tx_valid_o = tx_valid_reg;
  assign set_valid_o = set_valid_reg;
  assign set_item_o = set_item_reg;
  assign set_chan_o = set_chan_reg;
  assign set_value_o = set_value_reg;
  assign addr_o = addr_reg;
  assign err_o = err_reg;
  assign fwd_data_o = fwd_data_reg;
  assign fwd_valid_o = fwd_valid_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_query_exec;
    state_reg == S_EXEC && do_reply;
  endsequence
  sequence s_reply_run;
    state_reg == S_REPLY && !set_valid_reg;
  endsequence

  exec_on_lf_a: assert property (state_reg != S_EXEC && rx_take &&
    ch != CH_LF |=> state_reg != S_EXEC) else $error("exec without terminator");
  param_limit_a: assert property (pcount_reg <= PARAM_MAX)
    else $error("parameter count past limit");
  reply_only_value_a: assert property (push_valid |->
    (push_data >= CH_0 && push_data <= CH_9) || push_data == CH_DOT ||
    push_data == CH_LF) else $error("reply holds non value byte");
  addr_change_a: assert property ($changed(addr_reg) |->
    $past(addr_load))
    else $error("address changed without address command");
  addr_range_a: assert property (addr_reg >= ADDR_MASTER &&
    addr_reg <= ADDR_MAX) else $error("address out of range");
  single_chan_a: assert property (state_reg == S_EXEC && is_master &&
    !dual_s && chan != CHAN_NONE |=> err_reg && !set_valid_reg)
    else $error("suffix accepted on single channel unit");
  mode_conflict_a: assert property (state_reg == S_EXEC && is_master &&
    !query_reg && item inside {ITEM_VOLT, ITEM_CURR} && (seq_s || ext_s)
    |=> !set_valid_reg) else $error("setting applied during conflict");
  busy_holdoff_a: assert property (state_reg inside {S_EXEC, S_REPLY}
    |-> !rts_o && !rx_ready_o) else $error("host not held off while busy");
  cts_gate_a: assert property ($rose(tx_valid_reg) |-> $past(cts_s))
    else $error("byte started while partner held off");
  query_reply_a: assert property (s_query_exec |=> s_reply_run)
    else $error("query did not start a reply");
  err_no_set_a: assert property (err_reg |-> !set_valid_reg)
    else $error("error and setting in same cycle");
endmodule // tcp_text_cmd_parser

`default_nettype wire

// ---- testbench/tcp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// host computer model: sends lines, collects replies
// ----------------------------------------------------------------
module tcp_host_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic rts_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic slow_i
);
  logic [7:0] reply_q[$];
  bit stuck; // set when a byte was never accepted

  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
  end

  // one byte per handshake, held until rts was high before an edge
  task automatic send_line(input string s);
    logic rdy;
    int n;
    for (int i = 0; i < s.len(); i++) begin
      rx_data_o <= s[i];
      rx_valid_o <= 1'b1;
      n = 0;
      do begin
        @(negedge sys_clk_i);
        rdy = rts_i;
        @(posedge sys_clk_i);
        n++;
      end while (!rdy && n < 1000);
      if (!rdy) stuck = 1'b1;
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o; // stale data must not look valid
  endtask

  // slow mode stalls every other cycle to exercise the reply buffer
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      if (tx_valid_i && tx_ready_o) reply_q.push_back(tx_data_i);
      tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
    end
  end
endmodule // tcp_host_model

`default_nettype wire

// ---- testbench/test_text_command_parser.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t: got %0h want %0h", $time, a, b); end end

// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module test_text_command_parser import tcp_pkg::*;;
  logic sys_clk_i, reset_i, rx_valid, rx_ready, rts, tx_valid, tx_ready;
  logic cts, dual, seq, track, ext, set_valid, set_chan, err, fwd_valid;
  logic slow, last_chan;
  logic [7:0] rx_data, tx_data, fwd_data, last_fwd;
  logic [16:0] set_value, last_val;
  logic [4:0] addr;
  tcp_item_t set_item, last_item;
  int errors, n_checks, set_cnt, err_cnt, fwd_cnt;

  tcp_text_cmd_parser dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
    .rts_o(rts), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_ready), .cts_i(cts), .dual_chan_i(dual),
    .seq_active_i(seq), .track_active_i(track), .ext_active_i(ext),
    .set_valid_o(set_valid), .set_item_o(set_item), .set_chan_o(set_chan),
    .set_value_o(set_value), .addr_o(addr), .err_o(err),
    .fwd_data_o(fwd_data), .fwd_valid_o(fwd_valid));
  tcp_host_model host (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .rts_i(rts), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .slow_i(slow));

  // 40 ns clock
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // pulses last one cycle, so they are counted mid-cycle
  always @(negedge sys_clk_i) begin
    if (set_valid === 1'b1) begin
      set_cnt++;
      last_val = set_value;
      last_chan = set_chan;
      last_item = set_item;
    end
    if (err === 1'b1) err_cnt++;
    if (fwd_valid === 1'b1) begin
      fwd_cnt++;
      last_fwd = fwd_data;
    end
  end

  task automatic summarize;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one line, then a bounded wait until the parser listens again
  task automatic run(input string s, input bit hold);
    int k;
    set_cnt = 0;
    err_cnt = 0;
    fwd_cnt = 0;
    host.send_line(s);
    @(negedge sys_clk_i);
    if (hold) `CHK(rts, 1'b0)
    if (hold) `CHK(rx_ready, 1'b0)
    for (k = 0; k < 400 && rts !== 1'b1; k++) @(negedge sys_clk_i);
    if (k == 400 || host.stuck) begin
      errors++;
      summarize();
    end
    repeat (4) @(posedge sys_clk_i);
  endtask

  task automatic chk_set(input logic [16:0] v, logic ch, tcp_item_t it);
    `CHK(set_cnt, 1)
    `CHK(err_cnt, 0)
    `CHK(last_val, v)
    `CHK(last_chan, ch)
    `CHK(last_item, it)
  endtask

  task automatic chk_err;
    `CHK(err_cnt, 1)
    `CHK(set_cnt, 0)
  endtask

  // query; with stop the host withholds its handshake for a while
  task automatic query(input string s, string exp, bit stop);
    int k;
    host.reply_q.delete();
    set_cnt = 0;
    cts <= !stop;
    host.send_line(s);
    repeat (100) @(posedge sys_clk_i);
    if (stop) `CHK(host.reply_q.size(), 0)
    cts <= 1'b1;
    for (k = 0; k < 400 && host.reply_q.size() < exp.len(); k++)
      @(posedge sys_clk_i);
    if (k == 400 || host.stuck) begin
      errors++;
      summarize();
    end
    for (int i = 0; i < exp.len(); i++) `CHK(host.reply_q[i], 8'(exp[i]))
    `CHK(set_cnt, 0)
  endtask

  task automatic mode(input logic d, s, t, e);
    dual <= d;
    seq <= s;
    track <= t;
    ext <= e;
    repeat (4) @(posedge sys_clk_i); // synchroniser latency
  endtask

  task automatic t_settings;
    run(":VOLT 1.5\n", 1);
    chk_set(17'h00096, 1'b0, ITEM_VOLT);
    run(":curr 12\n", 1);
    chk_set(17'h004B0, 1'b0, ITEM_CURR);
    run(":Volt 1.235\n", 1);
    chk_set(17'h0007C, 1'b0, ITEM_VOLT);
    run(":VOLT 00000000157\n", 1);
    chk_set(17'h005DC, 1'b0, ITEM_VOLT);
  endtask

  task automatic t_reject;
    run(":FOO 1\n", 1);
    chk_err();
    run(":VOLT 1000\n", 1);
    chk_err();
    run(":VOLT:A 1\n", 1);
    chk_err();
  endtask

  task automatic t_channels;
    mode(1'b1, 1'b0, 1'b0, 1'b0);
    run(":VOLT:B 2\n", 1);
    chk_set(17'h000C8, 1'b1, ITEM_VOLT);
    run(":CURR:A 3\n", 1);
    chk_set(17'h0012C, 1'b0, ITEM_CURR);
    mode(1'b1, 1'b0, 1'b1, 1'b0);
    run(":VOLT:B 1\n", 1);
    chk_err();
    mode(1'b1, 1'b1, 1'b0, 1'b0);
    run(":CURR:A 1\n", 1);
    chk_err();
    mode(1'b1, 1'b0, 1'b0, 1'b1);
    run(":VOLT:A 1\n", 1);
    chk_err();
    mode(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_address;
    run(":ADDR 31\n", 1);
    chk_err();
    run(":ADDR 30\n", 1);
    `CHK(addr, 5'h1E)
    run(":VOLT 1\n", 0);
    `CHK(fwd_cnt, 8)
    `CHK(last_fwd, CH_LF)
    `CHK(set_cnt, 0)
    run(":addr 1\n", 0);
    `CHK(addr, ADDR_MASTER)
  endtask

  initial begin
    reset_i = 1'b1;
    cts = 1'b1;
    dual = 1'b0;
    seq = 1'b0;
    track = 1'b0;
    ext = 1'b0;
    slow = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    `CHK(addr, ADDR_MASTER)
    t_settings();
    slow <= 1'b1;
    query(":VOLT?\n", "15.00\n", 1'b1);
    query(":curr?\n", "12.00\n", 1'b0);
    t_reject();
    t_channels();
    t_address();
    summarize();
  end
endmodule // test_text_command_parser

`default_nettype wire
